// ### src/dcs_defs.svh
// offsets, field positions, reset values and timing counts of the sequencer
`ifndef DCS_DEFS_SVH
`define DCS_DEFS_SVH

`define DCS_CLK_HZ 50000000
`define DCS_TIMEOUT_MS 3000
`define DCS_SLEEP_S 600
`define DCS_BAUD 9600
`define DCS_TIMEOUT_CYC (64'(`DCS_TIMEOUT_MS) * 64'(`DCS_CLK_HZ) / 64'd1000)
`define DCS_SLEEP_CYC (64'(`DCS_SLEEP_S) * 64'(`DCS_CLK_HZ))
`define DCS_BIT_CYC (`DCS_CLK_HZ / `DCS_BAUD)

`define DCS_VMIN_MV 2400
`define DCS_VMAX_MV 4500
`define DCS_CHARGE_FULL 200
`define DCS_CHARGE_SAFE 40
`define DCS_CODE_MAX 255
`define DCS_PPM_STEP 10
`define DCS_TEMP_STEP_DC 2
`define DCS_DIGITS 5
`define DCS_ASCII_0 8'h30
`define DCS_ASCII_9 8'h39

`define DCS_OFS_CTRL 8'h00
`define DCS_OFS_VSTORE 8'h04
`define DCS_OFS_TEMP 8'h08
`define DCS_OFS_STATUS 8'h0c
`define DCS_OFS_CO2 8'h10
`define DCS_OFS_TELEGRAM 8'h14
`define DCS_OFS_CHARGE 8'h18

`define DCS_CTRL_EN_BIT 0
`define DCS_CTRL_KICK_BIT 1
`define DCS_ST_TMO_BIT 8
`define DCS_ST_SKIP_BIT 9
`define DCS_CTRL_RST 1'b1
`define DCS_VSTORE_RST 16'h0000
`define DCS_TEMP_RST 16'h0000

`define DCS_TEL_LRN 3
`define DCS_TEL_HUMV 2
`define DCS_TEL_TMPV 1

`define DCS_RESP_OKAY 2'b00
`define DCS_RESP_SLVERR 2'b10

`endif

// ### src/dcs_encode.sv
// scales storage voltage, co2 and temperature into telegram codes
`timescale 1ns/10ps
`default_nettype none
`include "dcs_defs.svh"
module dcs_encode (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [15:0] vstore_mv,
  input wire logic [15:0] temp_dc,
  input wire logic [16:0] co2_ppm,
  output logic [7:0] charge_code,
  output logic [31:0] telegram
);
  logic [31:0] dv, cq, pq, tq;
  logic [7:0] next_charge, co2_code, tmp_code;
  logic [31:0] next_tel;

  always_comb begin
    dv = (vstore_mv > 16'(`DCS_VMIN_MV)) ?
         32'(vstore_mv) - 32'(`DCS_VMIN_MV) : 32'h0000_0000;
    cq = dv * 32'(`DCS_CHARGE_FULL) / 32'(`DCS_VMAX_MV - `DCS_VMIN_MV); // see R13
    pq = 32'(co2_ppm) / 32'(`DCS_PPM_STEP); // see R16
    tq = 32'(temp_dc) / 32'(`DCS_TEMP_STEP_DC); // see R17
    // clamp rather than wrap, an overflowing code would read as low
    next_charge = (cq > 32'(`DCS_CHARGE_FULL)) ?
                  8'(`DCS_CHARGE_FULL) : cq[7:0]; // see R20
    co2_code = (pq > 32'(`DCS_CODE_MAX)) ? 8'(`DCS_CODE_MAX) : pq[7:0]; // see R20
    tmp_code = (tq > 32'(`DCS_CODE_MAX)) ? 8'(`DCS_CODE_MAX) : tq[7:0]; // see R20
    next_tel = {next_charge, co2_code, tmp_code, 8'h00}; // see R15
    next_tel[`DCS_TEL_LRN] = 1'b1;
    next_tel[`DCS_TEL_HUMV] = 1'b0;
    next_tel[`DCS_TEL_TMPV] = 1'b1;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      charge_code <= 8'h00;
      telegram <= 32'h0000_0000;
    end else begin
      charge_code <= next_charge;
      telegram <= next_tel;
    end
  end
endmodule
`default_nettype wire

// ### src/dcs_pkg.sv
// types shared by the sequencer files
package dcs_pkg;
  typedef enum logic [2:0] {
    ST_SLEEP, ST_CHECK, ST_WAIT, ST_RECV, ST_ENCODE, ST_LOAD, ST_SEND
  } dcs_state_e;
  typedef logic [39:0] dcs_cnt_t;
endpackage

// ### src/dcs_seq.sv
// duty-cycled gas sensor sequencer with its axi4-lite register slave
//
// Design decisions made here: the register offsets and the AXI4-Lite register port.
`timescale 1ns/10ps
`default_nettype none
`include "dcs_defs.svh"
// Behaviour
// R1: wake timer expiry starts a measurement cycle
// R2: after waking, switch sensor supply on
// R3: arm transmit-line wake and 3 s timeout
// R4: wait for sensor activity or timeout
// R5: sensor needs about two seconds to answer
// R6: sensor averages four internal measurements
// R7: sensor line: Z, value, z, value, CRLF
// R8: first falling edge on line wakes device
// R9: enable receiver, tolerate losing leading character
// R10: supply off after first five-digit value
// R11: convert concentration and transmit telegram
// R12: then load ten minutes, wake line disabled
// R13: charge scales 2.4 V..4.5 V to 0..100%
// R14: operate only at charge of 20% upward
// R15: first byte is charge in 0.5% steps
// R16: second byte is co2, 10 ppm steps
// R17: third byte is temperature, 0.2 C steps
// R18: low charge skips measurement and transmission
// R19: timeout: supply off, skip send, sleep
// R20: clamp codes to 255, charge to 200
module dcs_seq import dcs_pkg::*; #(
  parameter dcs_cnt_t TIMEOUT_CYC = 40'(`DCS_TIMEOUT_CYC),
  parameter dcs_cnt_t SLEEP_CYC = 40'(`DCS_SLEEP_CYC),
  parameter int BIT_CYC = `DCS_BIT_CYC
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic edge_wake_input,
  output logic sensor_power_ctl,
  output logic tx_valid,
  output logic [31:0] tx_data,
  input wire logic tx_ready
);
  // bus group
  logic aw_hold, w_hold, next_aw_hold, next_w_hold;
  logic [7:0] aw_addr, next_aw_addr;
  logic [31:0] w_data, next_w_data;
  logic [3:0] w_strb, next_w_strb;
  logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
  logic [1:0] next_bresp, next_rresp;
  logic [31:0] next_rdata;
  logic ctrl_en, next_ctrl_en;
  logic [15:0] vstore_mv, next_vstore_mv, temp_dc, next_temp_dc;
  logic flag_tmo, flag_skip, next_flag_tmo, next_flag_skip;
  logic do_write, kick;
  logic [7:0] wr_ofs;
  // sequencer group
  dcs_state_e state, next_state;
  dcs_cnt_t wake_cnt, next_wake_cnt, tmo_cnt, next_tmo_cnt;
  logic next_power, wake_armed, next_wake_armed, uart_en, next_uart_en;
  logic [2:0] ndig, next_ndig;
  logic [16:0] acc, next_acc, co2_ppm, next_co2_ppm;
  logic next_tx_valid;
  logic [31:0] next_tx_data;
  logic [15:0] sent_cnt, next_sent_cnt;
  logic ev_tmo, ev_skip;
  // synchroniser and helpers
  logic wake_s1, wake_s2, wake_prev;
  logic rx_valid;
  logic [7:0] rx_data;
  logic [7:0] charge_code;
  logic [31:0] telegram;

  assign do_write = aw_hold && w_hold && !s_axi_bvalid;
  assign wr_ofs = {aw_addr[7:2], 2'b00};
  assign kick = do_write && wr_ofs == `DCS_OFS_CTRL && w_strb[0] &&
                w_data[`DCS_CTRL_KICK_BIT];

  dcs_uart_rx #(.BIT_CYC(BIT_CYC)) u_rx (
    .clk(clk),
    .rst_b(rst_b),
    .en(uart_en),
    .rxd(wake_s2),
    .valid(rx_valid),
    .data(rx_data)
  );

  dcs_encode u_enc (
    .clk(clk),
    .rst_b(rst_b),
    .vstore_mv(vstore_mv),
    .temp_dc(temp_dc),
    .co2_ppm(co2_ppm),
    .charge_code(charge_code),
    .telegram(telegram)
  );

  // address and data are taken in either order; a write is done once both
  always_comb begin
    next_aw_hold = aw_hold;
    next_w_hold = w_hold;
    next_aw_addr = aw_addr;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = s_axi_bvalid;
    next_bresp = s_axi_bresp;
    next_rvalid = s_axi_rvalid;
    next_rresp = s_axi_rresp;
    next_rdata = s_axi_rdata;
    next_ctrl_en = ctrl_en;
    next_vstore_mv = vstore_mv;
    next_temp_dc = temp_dc;
    next_flag_tmo = flag_tmo;
    next_flag_skip = flag_skip;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_hold = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_hold = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (do_write) begin
      next_aw_hold = 1'b0;
      next_w_hold = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = `DCS_RESP_OKAY;
      case (wr_ofs)
        `DCS_OFS_CTRL: begin
          if (w_strb[0]) begin
            next_ctrl_en = w_data[`DCS_CTRL_EN_BIT];
          end
        end
        `DCS_OFS_VSTORE: begin
          for (int i = 0; i < 2; i++) begin
            if (w_strb[i]) begin
              next_vstore_mv[8*i +: 8] = w_data[8*i +: 8];
            end
          end
        end
        `DCS_OFS_TEMP: begin
          for (int i = 0; i < 2; i++) begin
            if (w_strb[i]) begin
              next_temp_dc[8*i +: 8] = w_data[8*i +: 8];
            end
          end
        end
        `DCS_OFS_STATUS: begin
          // write one to clear
          if (w_strb[1] && w_data[`DCS_ST_TMO_BIT]) begin
            next_flag_tmo = 1'b0;
          end
          if (w_strb[1] && w_data[`DCS_ST_SKIP_BIT]) begin
            next_flag_skip = 1'b0;
          end
        end
        `DCS_OFS_CO2, `DCS_OFS_TELEGRAM, `DCS_OFS_CHARGE: begin
          next_bresp = `DCS_RESP_OKAY;
        end
        default: begin
          next_bresp = `DCS_RESP_SLVERR;
        end
      endcase
    end
    // an event in the clearing cycle still sets its flag
    if (ev_tmo) begin
      next_flag_tmo = 1'b1;
    end
    if (ev_skip) begin
      next_flag_skip = 1'b1;
    end
    if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp = `DCS_RESP_OKAY;
      case ({s_axi_araddr[7:2], 2'b00})
        `DCS_OFS_CTRL: next_rdata = {31'h0000_0000, ctrl_en};
        `DCS_OFS_VSTORE: next_rdata = {16'h0000, vstore_mv};
        `DCS_OFS_TEMP: next_rdata = {16'h0000, temp_dc};
        `DCS_OFS_STATUS: next_rdata = {sent_cnt, 6'h00, flag_skip, flag_tmo,
                                       1'b0, uart_en, wake_armed,
                                       sensor_power_ctl, 1'b0, 3'(state)};
        `DCS_OFS_CO2: next_rdata = {15'h0000, co2_ppm};
        `DCS_OFS_TELEGRAM: next_rdata = tx_data;
        `DCS_OFS_CHARGE: next_rdata = {24'h00_0000, charge_code};
        default: begin
          next_rdata = 32'h0000_0000;
          next_rresp = `DCS_RESP_SLVERR;
        end
      endcase
    end
    next_awready = !next_aw_hold;
    next_wready = !next_w_hold;
    next_arready = !next_rvalid;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `DCS_RESP_OKAY;
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= `DCS_RESP_OKAY;
      s_axi_rdata <= 32'h0000_0000;
      ctrl_en <= `DCS_CTRL_RST;
      vstore_mv <= `DCS_VSTORE_RST;
      temp_dc <= `DCS_TEMP_RST;
      flag_tmo <= 1'b0;
      flag_skip <= 1'b0;
    end else begin
      aw_hold <= next_aw_hold;
      w_hold <= next_w_hold;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      s_axi_awready <= next_awready;
      s_axi_wready <= next_wready;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      s_axi_arready <= next_arready;
      s_axi_rvalid <= next_rvalid;
      s_axi_rresp <= next_rresp;
      s_axi_rdata <= next_rdata;
      ctrl_en <= next_ctrl_en;
      vstore_mv <= next_vstore_mv;
      temp_dc <= next_temp_dc;
      flag_tmo <= next_flag_tmo;
      flag_skip <= next_flag_skip;
    end
  end

  // measurement cycle
  always_comb begin
    next_state = state;
    next_wake_cnt = wake_cnt;
    next_tmo_cnt = tmo_cnt;
    next_power = sensor_power_ctl;
    next_wake_armed = wake_armed;
    next_uart_en = uart_en;
    next_ndig = ndig;
    next_acc = acc;
    next_co2_ppm = co2_ppm;
    next_tx_valid = tx_valid;
    next_tx_data = tx_data;
    next_sent_cnt = sent_cnt;
    ev_tmo = 1'b0;
    ev_skip = 1'b0;
    case (state)
      ST_SLEEP: begin
        if (kick) begin
          next_wake_cnt = '0;
        end else if (wake_cnt != '0) begin
          next_wake_cnt = wake_cnt - 40'h1;
        end else if (ctrl_en) begin
          next_state = ST_CHECK; // see R1
        end
      end
      ST_CHECK: begin
        // the supply dip of the sensor could brown out a drained store
        if (charge_code < 8'(`DCS_CHARGE_SAFE)) begin
          ev_skip = 1'b1; // see R14
          next_wake_cnt = SLEEP_CYC; // see R18
          next_state = ST_SLEEP;
        end else begin
          next_power = 1'b1; // see R2
          next_wake_armed = 1'b1; // see R3
          next_tmo_cnt = TIMEOUT_CYC; // see R3
          next_state = ST_WAIT;
        end
      end
      ST_WAIT, ST_RECV: begin
        next_tmo_cnt = tmo_cnt - 40'h1;
        if (state == ST_WAIT && wake_armed && wake_prev && !wake_s2) begin
          next_uart_en = 1'b1; // see R8
          next_ndig = 3'h0;
          next_acc = 17'h0_0000;
          next_state = ST_RECV; // see R4
        end
        if (state == ST_RECV && rx_valid && rx_data >= `DCS_ASCII_0 &&
            rx_data <= `DCS_ASCII_9) begin
          // letters and spaces are ignored, so a lost leader is harmless
          next_acc = 17'(acc * 17'd10 + 17'(rx_data - `DCS_ASCII_0)); // see R9
          next_ndig = ndig + 3'h1;
          if (ndig == 3'(`DCS_DIGITS - 1)) begin
            next_power = 1'b0; // see R10
            next_uart_en = 1'b0;
            next_co2_ppm = next_acc;
            next_state = ST_ENCODE;
          end
        end else if (tmo_cnt <= 40'h1) begin
          ev_tmo = 1'b1;
          next_power = 1'b0; // see R19
          next_uart_en = 1'b0;
          next_wake_armed = 1'b0;
          next_wake_cnt = SLEEP_CYC; // see R19
          next_state = ST_SLEEP;
        end
      end
      ST_ENCODE: begin
        next_state = ST_LOAD;
      end
      ST_LOAD: begin
        next_tx_data = telegram; // see R11
        next_tx_valid = 1'b1;
        next_state = ST_SEND;
      end
      ST_SEND: begin
        if (tx_ready) begin
          next_tx_valid = 1'b0;
          next_sent_cnt = sent_cnt + 16'h0001;
          next_wake_armed = 1'b0; // see R12
          next_wake_cnt = SLEEP_CYC; // see R12
          next_state = ST_SLEEP;
        end
      end
      default: begin
        next_state = ST_SLEEP;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wake_s1 <= 1'b1;
      wake_s2 <= 1'b1;
      wake_prev <= 1'b1;
      state <= ST_SLEEP;
      wake_cnt <= '0;
      tmo_cnt <= '0;
      sensor_power_ctl <= 1'b0;
      wake_armed <= 1'b0;
      uart_en <= 1'b0;
      ndig <= 3'h0;
      acc <= 17'h0_0000;
      co2_ppm <= 17'h0_0000;
      tx_valid <= 1'b0;
      tx_data <= 32'h0000_0000;
      sent_cnt <= 16'h0000;
    end else begin
      wake_s1 <= edge_wake_input;
      wake_s2 <= wake_s1;
      wake_prev <= wake_s2;
      state <= next_state;
      wake_cnt <= next_wake_cnt;
      tmo_cnt <= next_tmo_cnt;
      sensor_power_ctl <= next_power;
      wake_armed <= next_wake_armed;
      uart_en <= next_uart_en;
      ndig <= next_ndig;
      acc <= next_acc;
      co2_ppm <= next_co2_ppm;
      tx_valid <= next_tx_valid;
      tx_data <= next_tx_data;
      sent_cnt <= next_sent_cnt;
    end
  end
endmodule
`default_nettype wire

// ### src/dcs_uart_rx.sv
// 8n1 serial receiver, enabled only while a reply is expected
`timescale 1ns/10ps
`default_nettype none
module dcs_uart_rx #(
  parameter int BIT_CYC = 5208
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic en,
  input wire logic rxd,
  output logic valid,
  output logic [7:0] data
);
  localparam logic [15:0] BIT_M1 = 16'(BIT_CYC - 1);
  localparam logic [15:0] HALF = 16'(BIT_CYC / 2);
  logic busy, next_busy, next_valid;
  logic [15:0] cnt, next_cnt;
  logic [3:0] bitn, next_bitn;
  logic [7:0] sh, next_sh, next_data;

  // a low line at enable counts as a start bit: the edge that woke us
  // was the start bit of the first character
  always_comb begin
    next_busy = busy;
    next_cnt = cnt;
    next_bitn = bitn;
    next_sh = sh;
    next_valid = 1'b0;
    next_data = data;
    if (!en) begin
      next_busy = 1'b0;
    end else if (!busy) begin
      if (!rxd) begin
        next_busy = 1'b1;
        next_cnt = HALF;
        next_bitn = 4'h0;
      end
    end else if (cnt != 16'h0000) begin
      next_cnt = cnt - 16'h0001;
    end else begin
      next_cnt = BIT_M1;
      next_bitn = bitn + 4'h1;
      if (bitn == 4'h0 && rxd) begin
        next_busy = 1'b0;
      end else if (bitn == 4'h9) begin
        next_busy = 1'b0;
        next_valid = rxd;
        if (rxd) begin
          next_data = sh;
        end
      end else if (bitn != 4'h0) begin
        next_sh = {rxd, sh[7:1]};
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      busy <= 1'b0;
      cnt <= 16'h0000;
      bitn <= 4'h0;
      sh <= 8'h00;
      valid <= 1'b0;
      data <= 8'h00;
    end else begin
      busy <= next_busy;
      cnt <= next_cnt;
      bitn <= next_bitn;
      sh <= next_sh;
      valid <= next_valid;
      data <= next_data;
    end
  end
endmodule
`default_nettype wire

// ### tb/dcs_sensor_model.sv
// serial gas sensor stand-in: one ascii line per power-up
`timescale 1ns/10ps
`default_nettype none
module dcs_sensor_model #(
  parameter int BIT_CYC = 16,
  parameter int WARM_CYC = 300
) (
  input wire logic clk,
  input wire logic power,
  input wire logic mute,
  input wire logic [16:0] ppm,
  output logic txd
);
  logic bit_q = 1'b1;
  logic [7:0] c;
  // unpowered line sits at its pull-up level
  assign txd = power ? bit_q : 1'b1;
  function automatic logic [7:0] ch(input int k);
    int d;
    d = (k < 10) ? k - 2 : k - 10;
    case (k)
      0: return 8'h5a;
      1, 7, 9: return 8'h20;
      8: return 8'h7a;
      15: return 8'h0d;
      16: return 8'h0a;
      default: return 8'h30 + 8'((int'(ppm) / (10 ** (4 - d))) % 10);
    endcase
  endfunction
  initial begin
    forever begin
      @(posedge power);
      repeat (WARM_CYC) @(posedge clk);
      for (int k = 0; k < 17 && power && !mute; k++) begin
        c = ch(k);
        for (int b = 0; b < 10; b++) begin
          bit_q <= (b == 0) ? 1'b0 : (b == 9) ? 1'b1 : c[b - 1];
          repeat (BIT_CYC) @(posedge clk);
        end
      end
      bit_q <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// ### tb/dcs_seq_props.sv
// concurrent checks on the sequencer ports
`timescale 1ns/10ps
`default_nettype none
module dcs_seq_props import dcs_pkg::*; #(
  parameter dcs_cnt_t TIMEOUT_CYC = 40'd2000
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic edge_wake_input,
  input wire logic sensor_power_ctl,
  input wire logic tx_valid,
  input wire logic [31:0] tx_data,
  input wire logic tx_ready
);
  dcs_cnt_t on_cnt;
  dcs_cnt_t next_on_cnt;
  logic line_q;
  logic line_fell;
  logic next_line_fell;
  // powered span and any reply edge within it; both clear when power drops
  always_comb begin
    next_on_cnt = sensor_power_ctl ? on_cnt + 40'd1 : '0;
    next_line_fell = sensor_power_ctl &&
      (line_fell || (line_q && !edge_wake_input));
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      on_cnt <= '0;
      line_q <= 1'b1;
      line_fell <= 1'b0;
    end else begin
      on_cnt <= next_on_cnt;
      line_q <= edge_wake_input;
      line_fell <= next_line_fell;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence wr_answer;
    !s_axi_bvalid ##1 s_axi_bvalid;
  endsequence
  tx_hold_a: assert property (
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("telegram lost before it was taken");
  tx_done_a: assert property (
    tx_valid && tx_ready |=> !tx_valid)
    else $error("telegram offered twice");
  tx_unpowered_a: assert property (
    tx_valid |-> !sensor_power_ctl)
    else $error("sensor still powered while sending");
  tx_format_a: assert property (
    tx_valid |-> tx_data[7:0] == 8'h0a && tx_data[31:24] <= 8'd200)
    else $error("telegram low byte or charge code wrong");
  power_bound_a: assert property (
    sensor_power_ctl |-> on_cnt <= TIMEOUT_CYC + 40'd8)
    else $error("sensor powered past the timeout");
  power_cause_a: assert property (
    $fell(sensor_power_ctl) |-> line_fell || on_cnt + 40'd8 >= TIMEOUT_CYC)
    else $error("power dropped with no reply and no timeout");
  wr_resp_a: assert property (wr_take |=> wr_answer)
    else $error("write answer not two edges after take");
  rd_resp_a: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
endmodule
bind dcs_seq dcs_seq_props #(.TIMEOUT_CYC(TIMEOUT_CYC)) u_props (
  .clk(clk), .rst_b(rst_b), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .edge_wake_input(edge_wake_input),
  .sensor_power_ctl(sensor_power_ctl), .tx_valid(tx_valid),
  .tx_data(tx_data), .tx_ready(tx_ready));
`default_nettype wire

// ### tb/duty_cycled_gas_sensor_sequencer_test.sv
// self-checking bench for the gas sensor sequencer
`timescale 1ns/10ps
`default_nettype none
module duty_cycled_gas_sensor_sequencer_test import dcs_pkg::*; ;
  typedef struct {
    int mv;
    int dc;
    int ppm;
    logic [31:0] tel;
  } dcs_row_s;
  dcs_row_s rows [4] = '{'{4500, 250, 879, 32'hc8577d0a},
    '{4000, 600, 3000, 32'h98ffff0a}, '{2820, 0, 0, 32'h2800000a},
    '{3400, 511, 2549, 32'h5ffeff0a}};
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] s_axi_awaddr = '0;
  logic [7:0] s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic tx_ready = 1'b0;
  logic mute = 1'b0;
  logic [16:0] ppm = '0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, sensor_power_ctl, tx_valid, edge_wake_input;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr, br;
  logic [31:0] s_axi_rdata, tx_data, rd;
  int n_mismatch = 0;
  int samples_checked = 0;
  int n;
  // short counts keep the run to about ten thousand cycles
  dcs_seq #(.TIMEOUT_CYC(40'd2000), .SLEEP_CYC(40'd500), .BIT_CYC(16)) DUT (
    .clk(clk), .rst_b(rst_b), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .edge_wake_input(edge_wake_input), .sensor_power_ctl(sensor_power_ctl),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready));
  dcs_sensor_model #(.BIT_CYC(16), .WARM_CYC(300)) sensor (
    .clk(clk), .power(sensor_power_ctl), .mute(mute), .ppm(ppm),
    .txd(edge_wake_input));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic aw;
    logic w;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    aw = 1'b1;
    w = 1'b1;
    while (aw || w) begin
      @(posedge clk);
      if (s_axi_awready) begin
        aw = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wready) begin
        w = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end
    s_axi_bready <= 1'b1;
    do @(posedge clk); while (!s_axi_bvalid);
    br = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic wait_pw(input logic v, output int k);
    k = 0;
    while (sensor_power_ctl !== v && k < 5000) begin
      @(posedge clk);
      k++;
    end
  endtask
  // radio stalls three cycles before it takes the telegram
  task automatic take_tx();
    int k;
    k = 0;
    while (tx_valid !== 1'b1 && k < 5000) begin
      @(posedge clk);
      k++;
    end
    chk(32'(sensor_power_ctl), 32'h0);
    repeat (3) @(posedge clk);
    tx_ready <= 1'b1;
    @(posedge clk);
    tx_ready <= 1'b0;
  endtask
  initial begin
    forever #10 clk = ~clk;
  end
  initial begin
    repeat (40000) @(posedge clk);
    n_mismatch++;
    print_verdict();
  end
  initial begin
    repeat (6) @(posedge clk);
    chk(tx_data, 32'h0);
    chk(32'({sensor_power_ctl, tx_valid, s_axi_bvalid}), 32'h0);
    rst_b <= 1'b1;
    axi_rd(8'h00, rd, rr);
    chk(rd, 32'h1);
    axi_rd(8'h1c, rd, rr);
    chk(rd | 32'(rr), 32'h2);
    foreach (rows[i]) begin
      ppm <= 17'(rows[i].ppm);
      axi_wr(8'h04, 32'(rows[i].mv));
      axi_wr(8'h08, 32'(rows[i].dc));
      axi_wr(8'h00, 32'h3);
      take_tx();
      chk(tx_data, rows[i].tel);
    end
    axi_wr(8'h0c, 32'h200);
    axi_rd(8'h0c, rd, rr);
    chk(rd & 32'hffff0200, 32'h00040000);
    axi_wr(8'h04, 32'd2800);
    axi_wr(8'h00, 32'h3);
    repeat (20) @(posedge clk);
    chk(32'(sensor_power_ctl), 32'h0);
    axi_rd(8'h0c, rd, rr);
    chk(rd & 32'h200, 32'h200);
    mute <= 1'b1;
    axi_wr(8'h04, 32'd4500);
    axi_wr(8'h00, 32'h3);
    wait_pw(1'b1, n);
    wait_pw(1'b0, n);
    chk(32'(n > 1990 && n < 2010), 32'h1);
    axi_rd(8'h0c, rd, rr);
    chk(rd & 32'hffff0100, 32'h00040100);
    mute <= 1'b0;
    wait_pw(1'b1, n);
    chk(32'(n > 470 && n < 520), 32'h1);
    take_tx();
    // low byte only: the high byte of the stored voltage must survive
    s_axi_wstrb <= 4'h1;
    axi_wr(8'h04, 32'h0000ffe8);
    s_axi_wstrb <= 4'hf;
    chk(32'(br), 32'h0);
    axi_rd(8'h04, rd, rr);
    chk(rd, 32'h000011e8);
    axi_wr(8'h1c, 32'h0);
    chk(32'(br), 32'h2);
    // kick with enable off must not start a cycle
    axi_wr(8'h00, 32'h2);
    repeat (20) @(posedge clk);
    axi_rd(8'h0c, rd, rr);
    chk(rd & 32'h0000001f, 32'h0);
    axi_rd(8'h00, rd, rr);
    chk(rd, 32'h0);
    print_verdict();
  end
endmodule
`default_nettype wire
